/* File: core/ifu_defs.svh */
// Constants of the instruction fetch and program counter unit.
// Assumes inclusion by bare name from the package and the modules.
`ifndef IFU_DEFS_SVH
`define IFU_DEFS_SVH

// Counter and address widths
`define IFU_PC_W 13
`define IFU_ADDR_W 14
`define IFU_PAGE_W 8
`define IFU_RESET_VECTOR 13'h0000

// Register byte offsets
`define IFU_OFF_CTRL 12'h000
`define IFU_OFF_PCL 12'h004
`define IFU_OFF_CAP_LO 12'h008
`define IFU_OFF_CAP_HI 12'h00C
`define IFU_OFF_STAT 12'h010

// Field positions and reset values
`define IFU_CTRL_BANK_BIT 0
`define IFU_STAT_VALID_BIT 8
`define IFU_BANK_RESET 1'b0
`define IFU_CAP_RESET 8'h00

`endif

/* File: core/ifu_pkg.sv */
// Types shared by the fetch unit modules.
// Assumes ifu_defs.svh is on the include path.
`include "ifu_defs.svh"
package ifu_pkg;

  typedef enum logic [3:0] {
    PH_T1 = 4'h1,
    PH_T2 = 4'h2,
    PH_T3 = 4'h4,
    PH_T4 = 4'h8
  } phase_t;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_AND = 3'h1,
    ALU_OR = 3'h2,
    ALU_XOR = 3'h3,
    ALU_INC = 3'h4,
    ALU_DEC = 3'h5,
    ALU_RL = 3'h6,
    ALU_RR = 3'h7
  } alu_op_t;

  typedef struct packed {
    logic valid;
    logic [`IFU_PC_W-1:0] target;
  } branch_req_t;

  typedef struct packed {
    logic valid;
    alu_op_t op;
    logic [7:0] operand;
    logic skip_zero;
  } alu_req_t;

endpackage

/* File: core/instruction_fetch_pc_unit.sv */
// Instruction sequencing: phases, program counter, dummy cycles, capture.
// Assumes an APB master and an execute stage that pulses its requests.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ifu_defs.svh"
// Function
// - Four one-hot phases form one instruction cycle
// - Counter advances and fetch happens in first phase
// - Later phases execute, overlapping the next fetch
// - Branches take one extra instruction cycle
// - Counter increments by one after each instruction unless a jump or low byte write loads it
// - Bank-select bit forms top fetch address bit
// - Only counter low byte is software readable, writable
// - Low byte write jumps within page, dummy cycle
// - Met skip discards fetched instruction, dummy cycle
// - Jump, call, interrupt, reset load target directly
// - Low capture read returns low, buffers high byte
// - Read low before high; high returns buffer
// - One eight-bit ALU through the accumulator
// - Reset starts execution at address zero
module instruction_fetch_pc_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Execute stage requests
  input wire ifu_pkg::branch_req_t branch_req,
  input wire ifu_pkg::branch_req_t irq_req,
  input wire logic skip_req,
  input wire ifu_pkg::alu_req_t alu_req,
  // Fetch and execute status
  output ifu_pkg::phase_t phase,
  output logic fetch_en,
  output logic [`IFU_ADDR_W-1:0] fetch_addr,
  output logic exec_valid,
  output logic [`IFU_ADDR_W-1:0] exec_addr,
  output logic [7:0] acc
);
  localparam int PC_W = `IFU_PC_W;

  function automatic logic [7:0] alu8(input ifu_pkg::alu_op_t op,
                                      input logic [7:0] a,
                                      input logic [7:0] b);
    case (op)
      ifu_pkg::ALU_ADD: alu8 = a + b;
      ifu_pkg::ALU_AND: alu8 = a & b;
      ifu_pkg::ALU_OR: alu8 = a | b;
      ifu_pkg::ALU_XOR: alu8 = a ^ b;
      ifu_pkg::ALU_INC: alu8 = a + 8'h01;
      ifu_pkg::ALU_DEC: alu8 = a - 8'h01;
      ifu_pkg::ALU_RL: alu8 = {a[6:0], a[7]};
      ifu_pkg::ALU_RR: alu8 = {a[0], a[7:1]};
      default: alu8 = a;
    endcase
  endfunction

  logic [PC_W-1:0] pc_reg, pc_next;
  logic bank_reg, bank_next;
  logic jump_pend_reg, pcl_pend_reg, skip_pend_reg;
  logic [PC_W-1:0] jump_tgt_reg;
  logic [7:0] pcl_val_reg;
  logic fetch_en_reg, exec_valid_reg;
  logic [`IFU_ADDR_W-1:0] fetch_addr_reg, exec_addr_reg;
  logic [7:0] acc_reg, acc_next;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic [7:0] cap_high;

  // Phase ring
  phase_gen u_phase (
    .pclk(pclk),
    .presetn(presetn),
    .phase_q(phase)
  );

  // APB decode
  wire sel_ctrl = paddr == `IFU_OFF_CTRL;
  wire sel_pcl = paddr == `IFU_OFF_PCL;
  wire sel_cap_lo = paddr == `IFU_OFF_CAP_LO;
  wire sel_cap_hi = paddr == `IFU_OFF_CAP_HI;
  wire sel_stat = paddr == `IFU_OFF_STAT;
  wire mapped = sel_ctrl | sel_pcl | sel_cap_lo | sel_cap_hi | sel_stat;
  wire setup = psel & ~penable;
  wire done = psel & penable & pready_reg;
  wire apb_wr = done & pwrite & mapped;
  wire pcl_wr = apb_wr & sel_pcl;
  wire cap_lo_rd = done & ~pwrite & sel_cap_lo;
  wire [31:0] stat_word = {23'h0, exec_valid_reg, 4'h0, phase};
  wire [31:0] rd_data =
    sel_ctrl ? {31'h0, bank_reg} :
    sel_pcl ? {24'h0, pc_reg[7:0]} :
    sel_cap_lo ? {24'h0, exec_addr_reg[7:0]} :
    sel_cap_hi ? {24'h0, cap_high} :
    sel_stat ? stat_word : 32'h0;

  // Sequencing decisions
  wire cyc_end = phase == ifu_pkg::PH_T4;
  wire [7:0] alu_res = alu8(alu_req.op, acc_reg, alu_req.operand);
  wire alu_skip = alu_req.valid & alu_req.skip_zero & (alu_res == 8'h00);
  wire jump_now = branch_req.valid | irq_req.valid | jump_pend_reg;
  wire [PC_W-1:0] tgt_now = irq_req.valid ? irq_req.target :
                            branch_req.valid ? branch_req.target :
                            jump_tgt_reg;
  wire pcl_now = pcl_wr | pcl_pend_reg;
  wire [7:0] pcl_val_now = pcl_wr ? pwdata[7:0] : pcl_val_reg;
  wire skip_now = skip_req | alu_skip | skip_pend_reg;
  wire redirect = jump_now | pcl_now | skip_now;
  wire [PC_W-1:0] pc_inc = pc_reg + 13'h0001;
  wire [PC_W-1:0] pc_page = {pc_reg[PC_W-1:8], pcl_val_now};

  always_comb begin
    pc_next = pc_reg;
    if (cyc_end) begin
      if (jump_now) begin
        pc_next = tgt_now;
      end else if (pcl_now) begin
        pc_next = pc_page;
      end else begin
        pc_next = pc_inc;
      end
    end
  end

  assign bank_next = (apb_wr & sel_ctrl) ?
                     pwdata[`IFU_CTRL_BANK_BIT] : bank_reg;
  assign acc_next = alu_req.valid ? alu_res : acc_reg;

  // Counter advances entering T1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= `IFU_RESET_VECTOR;
      bank_reg <= `IFU_BANK_RESET;
      acc_reg <= 8'h00;
    end else begin
      pc_reg <= pc_next;
      bank_reg <= bank_next;
      acc_reg <= acc_next;
    end
  end

  // Requests held until the cycle ends; a later jump replaces a pending target, and a jump drops a pending low byte write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jump_pend_reg <= 1'b0;
      jump_tgt_reg <= `IFU_RESET_VECTOR;
      pcl_pend_reg <= 1'b0;
      pcl_val_reg <= 8'h00;
      skip_pend_reg <= 1'b0;
    end else begin
      jump_pend_reg <= jump_now & ~cyc_end;
      jump_tgt_reg <= tgt_now;
      pcl_pend_reg <= pcl_now & ~cyc_end;
      pcl_val_reg <= pcl_val_now;
      skip_pend_reg <= skip_now & ~cyc_end;
    end
  end

  // Fetch and execute stage registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_en_reg <= 1'b1;
      fetch_addr_reg <= {`IFU_BANK_RESET, `IFU_RESET_VECTOR};
      exec_valid_reg <= 1'b0;
      exec_addr_reg <= {`IFU_BANK_RESET, `IFU_RESET_VECTOR};
    end else begin
      fetch_en_reg <= cyc_end;
      if (cyc_end) begin
        fetch_addr_reg <= {bank_reg, pc_next};
        exec_valid_reg <= ~redirect;
        exec_addr_reg <= fetch_addr_reg;
      end
    end
  end

  // APB answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        prdata_reg <= pwrite ? 32'h0 : rd_data;
        pslverr_reg <= ~mapped;
      end
    end
  end

  pc_capture u_cap (
    .pclk(pclk),
    .presetn(presetn),
    .cap_lo_rd(cap_lo_rd),
    .exec_addr(exec_addr_reg),
    .high_buf(cap_high)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign fetch_en = fetch_en_reg;
  assign fetch_addr = fetch_addr_reg;
  assign exec_valid = exec_valid_reg;
  assign exec_addr = exec_addr_reg;
  assign acc = acc_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_phase_ring;
    phase == ifu_pkg::PH_T1 |-> $onehot(phase) ##4 phase == ifu_pkg::PH_T1;
  endproperty
  a_phase_ring: assert property (p_phase_ring)
    else $error("phase ring broken");

  property p_fetch_t1;
    fetch_en |-> phase == ifu_pkg::PH_T1 &&
      ($past(phase) == ifu_pkg::PH_T4 || !$past(presetn));
  endproperty
  a_fetch_t1: assert property (p_fetch_t1)
    else $error("fetch outside first phase");

  property p_exec_stable;
    phase != ifu_pkg::PH_T1 |-> $stable(exec_valid) && $stable(exec_addr);
  endproperty
  a_exec_stable: assert property (p_exec_stable)
    else $error("execute stage changed mid cycle");

  property p_redirect_dummy;
    cyc_end && redirect |=> !exec_valid [*4];
  endproperty
  a_redirect_dummy: assert property (p_redirect_dummy)
    else $error("redirect without dummy cycle");

  property p_seq_inc;
    cyc_end && !jump_now && !pcl_now |=> pc_reg == $past(pc_inc);
  endproperty
  a_seq_inc: assert property (p_seq_inc)
    else $error("counter did not increment");

  property p_bank_addr;
    fetch_en |-> fetch_addr == {$past(bank_reg), pc_reg};
  endproperty
  a_bank_addr: assert property (p_bank_addr)
    else $error("fetch address bank bit wrong");

  property p_pcl_read;
    setup && sel_pcl && !pwrite |=> prdata == {24'h0, $past(pc_reg[7:0])};
  endproperty
  a_pcl_read: assert property (p_pcl_read)
    else $error("low counter read wrong");

  property p_pcl_jump;
    cyc_end && pcl_now && !jump_now |=>
      pc_reg == {$past(pc_reg[12:8]), $past(pcl_val_now)} && !exec_valid;
  endproperty
  a_pcl_jump: assert property (p_pcl_jump)
    else $error("low byte jump left page");

  property p_jump_load;
    cyc_end && jump_now |=> pc_reg == $past(tgt_now) ##4 fetch_en;
  endproperty
  a_jump_load: assert property (p_jump_load)
    else $error("jump target not loaded");

  property p_cap_hi;
    setup && sel_cap_hi && !pwrite |=> prdata == {24'h0, $past(cap_high)};
  endproperty
  a_cap_hi: assert property (p_cap_hi)
    else $error("high capture not from buffer");

  property p_alu_inc;
    alu_req.valid && alu_req.op == ifu_pkg::ALU_INC |=>
      acc == $past(acc) + 8'h01;
  endproperty
  a_alu_inc: assert property (p_alu_inc)
    else $error("accumulator increment wrong");

  c_jump: cover property (cyc_end && jump_now);
  c_skip: cover property (cyc_end && skip_now && !jump_now && !pcl_now);
  c_pcl_write: cover property (pcl_wr);
  c_capture: cover property (cap_lo_rd ##[1:20] (done && sel_cap_hi));
endmodule // instruction_fetch_pc_unit
`default_nettype wire

/* File: core/pc_capture.sv */
// Holding buffer for the high byte of the execution address.
// Assumes a one cycle read strobe for the low capture register.
`timescale 1ns/1ps
`default_nettype none
`include "ifu_defs.svh"
module pc_capture (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Capture request
  input wire logic cap_lo_rd,
  input wire logic [`IFU_ADDR_W-1:0] exec_addr,
  // Buffered high byte
  output logic [7:0] high_buf
);
  logic [7:0] high_next;

  assign high_next = cap_lo_rd ? 8'(exec_addr[`IFU_ADDR_W-1:8]) : high_buf;

  // Copied on a low read, held otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_buf <= `IFU_CAP_RESET;
    end else begin
      high_buf <= high_next;
    end
  end

  property p_buf_hold;
    @(posedge pclk) disable iff (!presetn)
    !cap_lo_rd |=> $stable(high_buf);
  endproperty
  a_buf_hold: assert property (p_buf_hold)
    else $error("capture buffer changed without low read");

  property p_buf_load;
    @(posedge pclk) disable iff (!presetn)
    cap_lo_rd |=> high_buf == {2'h0, $past(exec_addr[13:8])};
  endproperty
  a_buf_load: assert property (p_buf_load)
    else $error("capture buffer missed high byte");
endmodule // pc_capture
`default_nettype wire

/* File: core/phase_gen.sv */
// Four phase ring that splits pclk into instruction phases.
// Assumes one free running clock and asynchronous active low reset.
`timescale 1ns/1ps
`default_nettype none
`include "ifu_defs.svh"
module phase_gen (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Current phase
  output ifu_pkg::phase_t phase_q
);
  ifu_pkg::phase_t phase_next;

  // Ring T1, T2, T3, T4, back to T1
  always_comb begin
    case (phase_q)
      ifu_pkg::PH_T1: phase_next = ifu_pkg::PH_T2;
      ifu_pkg::PH_T2: phase_next = ifu_pkg::PH_T3;
      ifu_pkg::PH_T3: phase_next = ifu_pkg::PH_T4;
      ifu_pkg::PH_T4: phase_next = ifu_pkg::PH_T1;
      default: phase_next = ifu_pkg::PH_T1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= ifu_pkg::PH_T1;
    end else begin
      phase_q <= phase_next;
    end
  end
endmodule // phase_gen
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the fetch and program counter unit.
// Assumes the core package and modules are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "ifu_defs.svh"
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, skip_req;
  logic fetch_en, exec_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  ifu_pkg::branch_req_t branch_req, irq_req;
  ifu_pkg::alu_req_t alu_req;
  ifu_pkg::phase_t phase;
  logic [13:0] fetch_addr, exec_addr;
  logic [7:0] acc;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int err_count = 0;
  int n_compared = 0;

  always #5 pclk = ~pclk;

  instruction_fetch_pc_unit u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .branch_req(branch_req),
    .irq_req(irq_req), .skip_req(skip_req), .alu_req(alu_req),
    .phase(phase), .fetch_en(fetch_en), .fetch_addr(fetch_addr),
    .exec_valid(exec_valid), .exec_addr(exec_addr), .acc(acc)
  );

  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask

  task results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Read results leave the queue as they complete
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      chk("prdata", prdata, e[31:0]);
      chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
    end
  end

  // One APB transfer; reads note their expectation
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic er);
    int k;
    if (!w) exp_q.push_back({er, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task to_t1;
    do begin
      @(posedge pclk);
      #1;
    end while (phase !== ifu_pkg::PH_T1);
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    results();
  end

  initial begin
    logic [13:0] fa;
    logic [12:0] t, t2;
    logic [7:0] v, a;
    int i;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    branch_req = '0;
    irq_req = '0;
    skip_req = 1'b0;
    alu_req = '0;
    void'($urandom(32'he043));
    repeat (16) @(posedge pclk);
    #1;
    chk("phase", 32'(phase), 32'h1);
    chk("fetch_addr", 32'(fetch_addr), 32'h0);
    chk("exec_valid", 32'(exec_valid), 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `IFU_OFF_CAP_HI, 32'h0, 1'b0);
    apb(1'b0, `IFU_OFF_CTRL, 32'h0, 1'b0);
    $display("test reset done");
    to_t1();
    for (i = 0; i < 8; i++) begin
      chk("phase", 32'(phase), 32'h1 << (i % 4));
      chk("fetch_en", 32'(fetch_en), 32'(i % 4 == 0));
      @(posedge pclk);
      #1;
    end
    fa = fetch_addr;
    to_t1();
    chk("fetch_addr", 32'(fetch_addr), 32'(fa + 14'h1));
    chk("exec_addr", 32'(exec_addr), 32'(fa));
    chk("exec_valid", 32'(exec_valid), 32'h1);
    $display("test phases done");
    t = 13'($urandom);
    @(posedge pclk);
    branch_req <= {1'b1, t};
    @(posedge pclk);
    branch_req <= '0;
    to_t1();
    chk("fetch_addr", 32'(fetch_addr), {19'h0, t});
    chk("exec_valid", 32'(exec_valid), 32'h0);
    to_t1();
    chk("fetch_addr", 32'(fetch_addr), 32'(t + 13'h1));
    chk("exec_valid", 32'(exec_valid), 32'h1);
    chk("exec_addr", 32'(exec_addr), {19'h0, t});
    apb(1'b0, `IFU_OFF_CAP_LO, {24'h0, t[7:0]}, 1'b0);
    apb(1'b0, `IFU_OFF_CAP_HI, {27'h0, t[12:8]}, 1'b0);
    to_t1();
    to_t1();
    apb(1'b0, `IFU_OFF_CAP_HI, {27'h0, t[12:8]}, 1'b0);
    $display("test branch and capture done");
    to_t1();
    t2 = 13'($urandom);
    @(posedge pclk);
    branch_req <= {1'b1, t};
    irq_req <= {1'b1, t2};
    @(posedge pclk);
    branch_req <= '0;
    irq_req <= '0;
    to_t1();
    chk("fetch_addr", 32'(fetch_addr), {19'h0, t2});
    fa = fetch_addr;
    @(posedge pclk);
    skip_req <= 1'b1;
    @(posedge pclk);
    skip_req <= 1'b0;
    to_t1();
    chk("fetch_addr", 32'(fetch_addr), 32'({fa[13], fa[12:0] + 13'h1}));
    chk("exec_valid", 32'(exec_valid), 32'h0);
    $display("test interrupt and skip done");
    to_t1();
    fa = fetch_addr;
    v = 8'($urandom);
    apb(1'b1, `IFU_OFF_PCL, {24'h0, v}, 1'b0);
    to_t1();
    chk("fetch_addr", 32'(fetch_addr), {18'h0, fa[13:8], v});
    chk("exec_valid", 32'(exec_valid), 32'h0);
    to_t1();
    apb(1'b0, `IFU_OFF_PCL, {24'h0, v + 8'h01}, 1'b0);
    apb(1'b1, `IFU_OFF_CTRL, 32'h1, 1'b0);
    apb(1'b0, `IFU_OFF_CTRL, 32'h1, 1'b0);
    to_t1();
    chk("bank bit", 32'(fetch_addr[13]), 32'h1);
    apb(1'b0, `IFU_OFF_STAT, 32'h0000_0102, 1'b0);
    apb(1'b1, `IFU_OFF_CTRL, 32'h0, 1'b0);
    apb(1'b0, 12'h020, 32'h0, 1'b1);
    $display("test registers done");
    a = 8'h00;
    for (i = 0; i < 8; i++) begin
      v = 8'($urandom);
      @(posedge pclk);
      alu_req <= {1'b1, i[2:0], v, 1'b0};
      @(posedge pclk);
      alu_req <= '0;
      #1;
      case (i)
        0: a = a + v;
        1: a = a & v;
        2: a = a | v;
        3: a = a ^ v;
        4: a = a + 8'h01;
        5: a = a - 8'h01;
        6: a = {a[6:0], a[7]};
        default: a = {a[0], a[7:1]};
      endcase
      chk("acc", 32'(acc), {24'h0, a});
    end
    to_t1();
    fa = fetch_addr;
    @(posedge pclk);
    alu_req <= {1'b1, 3'h1, 8'h00, 1'b1};
    @(posedge pclk);
    alu_req <= '0;
    to_t1();
    chk("fetch_addr", 32'(fetch_addr), 32'({fa[13], fa[12:0] + 13'h1}));
    chk("exec_valid", 32'(exec_valid), 32'h0);
    chk("acc", 32'(acc), 32'h0);
    $display("test alu done");
    results();
  end
endmodule // testbench
`default_nettype wire
